// file: design/csr_dev.sv
// The microprocessor host port (csr_if) was chosen for this implementation.
`timescale 1ns/100ps
`include "csr_defines.svh"
`default_nettype none
module csr_dev #(
  parameter int BUF_DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  csr_if.dev bus,
  input wire logic mode_select_pin_i,
  input wire logic [2:0] design_slot_select_i,
  input wire logic chain_lock_req_i,
  output logic chain_lock_held_o,
  output logic chain_ctrl_reset_o,
  output csr_pkg::csr_src_t config_source_o,
  output logic [2:0] design_slot_o,
  output logic config_go_o,
  input wire logic card_cmd_ready_i,
  output logic card_read_start_o,
  output logic [27:0] card_lba_o,
  output logic [7:0] card_count_o,
  input wire logic [15:0] card_data_i,
  input wire logic card_data_valid_i,
  output logic card_data_ready_o
);
  ////////////////////////////////////////////////////////////////////////////
  logic [27:0] lba_r;
  logic [7:0] count_r;
  logic [7:0] cmd_r;
  logic [15:0] ctrl_r;
  logic host_lock_r;
  logic chain_lock_r;
  logic chain_rst_r;
  logic rd_active_r;
  logic wr_active_r;
  logic [15:0] push_left_r;
  logic [15:0] rdata_r;
  logic rdata_oe_r;
  logic start_r;
  csr_pkg::csr_src_t src_r;
  logic [2:0] slot_r;
  logic go_r;

  logic wr;
  logic rd;
  logic [6:0] waddr;
  logic wr_lo;
  logic wr_hi;
  logic [7:0] hi_byte;
  logic is_buf;
  logic pop;
  logic buf_full;
  logic buf_valid;
  logic buf_in_ready;
  logic [15:0] buf_data;
  logic buf_ready;
  logic cmd_ready;
  logic cmd_read;
  logic chain_set;
  logic [15:0] status;
  logic [15:0] rword;
  logic mode_eff;

  ////////////////////////////////////////////////////////////////////////////
  // Host port decode
  assign wr = bus.mp_ce && bus.mp_we;
  assign rd = bus.mp_ce && bus.mp_oe && !bus.mp_we;
  assign waddr = {bus.mp_addr[6:1], 1'b0};
  assign is_buf = bus.mp_addr[`CSR_BUF_BIT];
  assign wr_lo = wr && (!bus.mp_byte_mode || !bus.mp_addr[0]);
  assign wr_hi = wr && (!bus.mp_byte_mode || bus.mp_addr[0]);
  assign hi_byte = bus.mp_byte_mode ? bus.mp_d[7:0] : bus.mp_d[15:8];
  // Pop on a buffer read: odd byte in byte mode, every buffer read in word mode
  assign pop = rd && is_buf && (!bus.mp_byte_mode || bus.mp_addr[0]);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lba_r <= '0;
      count_r <= '0;
      cmd_r <= '0;
      ctrl_r <= '0;
    end else begin
      if (wr_lo && waddr == `CSR_ADR_LBA_LO) begin
        lba_r[7:0] <= bus.mp_d[7:0];
      end
      if (wr_hi && waddr == `CSR_ADR_LBA_LO) begin
        lba_r[15:8] <= hi_byte;
      end
      if (wr_lo && waddr == `CSR_ADR_LBA_HI) begin
        lba_r[23:16] <= bus.mp_d[7:0];
      end
      if (wr_hi && waddr == `CSR_ADR_LBA_HI) begin
        lba_r[27:24] <= hi_byte[3:0];
      end
      if (wr_lo && waddr == `CSR_ADR_CNTCMD) begin
        count_r <= bus.mp_d[7:0];
      end
      if (wr_hi && waddr == `CSR_ADR_CNTCMD) begin
        cmd_r <= hi_byte;
      end
      if (wr_lo && waddr == `CSR_ADR_CTRL) begin
        ctrl_r[7:0] <= bus.mp_d[7:0];
      end
      if (wr_hi && waddr == `CSR_ADR_CTRL) begin
        ctrl_r[15:8] <= hi_byte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Card lock arbitration; the chain side wins a same-cycle tie
  assign chain_set = chain_lock_req_i && !host_lock_r && !chain_rst_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chain_lock_r <= 1'b0;
    end else if (ctrl_r[`CSR_CTL_CRESET] && ctrl_r[`CSR_CTL_FORCE]) begin
      chain_lock_r <= 1'b0;
    end else if (!chain_lock_req_i) begin
      chain_lock_r <= 1'b0;
    end else if (chain_set) begin
      chain_lock_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      host_lock_r <= 1'b0;
    end else if (!ctrl_r[`CSR_CTL_CARD_LOCK_REQUEST]) begin
      host_lock_r <= 1'b0;
    end else if (!chain_lock_r && !chain_set) begin
      host_lock_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chain_rst_r <= 1'b1;
    end else begin
      chain_rst_r <= ctrl_r[`CSR_CTL_CRESET];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sector command: accepted only with the lock held and the card idle
  assign cmd_ready = card_cmd_ready_i && !rd_active_r && !wr_active_r;
  assign cmd_read = wr_hi && waddr == `CSR_ADR_CNTCMD && hi_byte == `CSR_CMD_READ
    && host_lock_r && cmd_ready;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_active_r <= 1'b0;
      wr_active_r <= 1'b0;
      push_left_r <= '0;
      start_r <= 1'b0;
    end else begin
      start_r <= cmd_read;
      if (cmd_read) begin
        rd_active_r <= 1'b1;
        push_left_r <= {(wr_lo ? bus.mp_d[7:0] : count_r), 8'h00};
      end else begin
        if (card_data_valid_i && card_data_ready_o) begin
          push_left_r <= push_left_r - 16'h0001;
        end
        // Read ends once the card supplied everything and it was drained
        if (rd_active_r && push_left_r == '0 && !buf_valid) begin
          rd_active_r <= 1'b0;
        end
      end
      // Write path is not built; the flag only steers buffer ready and holds off command ready
      if (wr_hi && waddr == `CSR_ADR_CNTCMD && hi_byte == `CSR_CMD_WRITE && host_lock_r
          && cmd_ready) begin
        wr_active_r <= 1'b1;
      end else if (!host_lock_r) begin
        wr_active_r <= 1'b0;
      end
    end
  end

  assign card_read_start_o = start_r;
  assign card_lba_o = lba_r;
  assign card_count_o = count_r;
  assign card_data_ready_o = rd_active_r && push_left_r != '0 && buf_in_ready;

  csr_buf #(
    .WIDTH(16),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(card_data_valid_i && rd_active_r && push_left_r != '0),
    .in_ready_o(buf_in_ready),
    .in_data_i(card_data_i),
    .out_valid_o(buf_valid),
    .out_pop_i(pop),
    .out_data_o(buf_data),
    .full_o(buf_full)
  );

  assign buf_ready = (rd_active_r && buf_full) || (wr_active_r && !buf_valid);

  ////////////////////////////////////////////////////////////////////////////
  // Status and read data
  always_comb begin
    status = '0;
    status[`CSR_ST_CHAIN_LOCK] = chain_lock_r;
    status[`CSR_ST_HOST_LOCK] = host_lock_r;
    status[`CSR_ST_BUF_RDY] = buf_ready;
    status[`CSR_ST_CMD_RDY] = cmd_ready;
    status[`CSR_ST_RD_ACTIVE] = rd_active_r;
  end

  always_comb begin
    if (is_buf) begin
      rword = buf_data;
    end else begin
      case (waddr)
        `CSR_ADR_STATUS: rword = status;
        `CSR_ADR_LBA_LO: rword = lba_r[15:0];
        `CSR_ADR_LBA_HI: rword = {4'h0, lba_r[27:16]};
        `CSR_ADR_CNTCMD: rword = {cmd_r, count_r};
        `CSR_ADR_CTRL: rword = ctrl_r;
        default: rword = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_r <= '0;
      rdata_oe_r <= 1'b0;
    end else begin
      rdata_oe_r <= rd;
      if (rd) begin
        if (bus.mp_byte_mode) begin
          rdata_r <= {8'h00, bus.mp_addr[0] ? rword[15:8] : rword[7:0]};
        end else begin
          rdata_r <= rword;
        end
      end
    end
  end

  assign bus.dev_d = rdata_r;
  assign bus.dev_d_oe = rdata_oe_r;
  assign bus.buffer_ready_pin = buf_ready;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration source selection
  assign mode_eff = ctrl_r[`CSR_CTL_MODE_OVR] ? ctrl_r[`CSR_CTL_MODE] : mode_select_pin_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_r <= csr_pkg::CSR_SRC_IDLE;
      slot_r <= '0;
      go_r <= 1'b0;
    end else begin
      go_r <= ctrl_r[`CSR_CTL_GO];
      // Slot pins ignored under override
      slot_r <= ctrl_r[`CSR_CTL_SLOT_OVR] ? ctrl_r[`CSR_CTL_SLOT_LSB +: 3]
        : design_slot_select_i;
      if (chain_rst_r) begin
        src_r <= csr_pkg::CSR_SRC_IDLE;
      end else if (mode_eff && !ctrl_r[`CSR_CTL_SEL]) begin
        src_r <= csr_pkg::CSR_SRC_CARD;
      end else if (mode_eff && !ctrl_r[`CSR_CTL_GO]) begin
        src_r <= csr_pkg::CSR_SRC_TEST;
      end else if (mode_eff) begin
        src_r <= csr_pkg::CSR_SRC_HOST;
      end else if (ctrl_r[`CSR_CTL_GO] && !ctrl_r[`CSR_CTL_SEL]) begin
        src_r <= csr_pkg::CSR_SRC_CARD;
      end else if (ctrl_r[`CSR_CTL_GO]) begin
        src_r <= csr_pkg::CSR_SRC_HOST;
      end else begin
        src_r <= csr_pkg::CSR_SRC_IDLE;
      end
    end
  end

  assign config_source_o = src_r;
  assign design_slot_o = slot_r;
  assign config_go_o = go_r;
  assign chain_lock_held_o = chain_lock_r;
  assign chain_ctrl_reset_o = chain_rst_r;
endmodule
`default_nettype wire

// file: design/csr_defines.svh
`ifndef CSR_DEFINES_SVH
`define CSR_DEFINES_SVH

// Host-port byte addresses (word registers sit on even addresses)
`define CSR_ADR_STATUS 7'h04
`define CSR_ADR_LBA_LO 7'h10
`define CSR_ADR_LBA_HI 7'h12
`define CSR_ADR_CNTCMD 7'h14
`define CSR_ADR_CTRL 7'h18
`define CSR_ADR_CMDRDY 7'h05
`define CSR_BUF_BIT 6
`define CSR_ADR_BUF 7'h40

// Control word bits
`define CSR_CTL_FORCE 0
`define CSR_CTL_CARD_LOCK_REQUEST 1
`define CSR_CTL_MODE_OVR 3
`define CSR_CTL_MODE 4
`define CSR_CTL_GO 5
`define CSR_CTL_SEL 6
`define CSR_CTL_CRESET 7
`define CSR_CTL_SLOT_LSB 8
`define CSR_CTL_SLOT_OVR 11

// Status word bits
`define CSR_ST_CHAIN_LOCK 0
`define CSR_ST_HOST_LOCK 1
`define CSR_ST_BUF_RDY 5
`define CSR_ST_CMD_RDY 8
`define CSR_ST_RD_ACTIVE 9

// Commands and sizes
`define CSR_CMD_READ 8'h03
`define CSR_CMD_WRITE 8'h04
`define CSR_SECTOR_WORDS_LOG2 8
`define CSR_BURST_WORDS 5'h10

// Host-side Wishbone map
`define CSR_WB_CTRL 5'h00
`define CSR_WB_LBA 5'h04
`define CSR_WB_COUNT 5'h08
`define CSR_WB_STATUS 5'h0C
`define CSR_WB_LAST 5'h10
`define CSR_WB_CFG 5'h14

`endif

// file: design/csr_pkg.sv
package csr_pkg;

  typedef enum logic [3:0] {
    CSR_SRC_IDLE = 4'b0001,
    CSR_SRC_CARD = 4'b0010,
    CSR_SRC_HOST = 4'b0100,
    CSR_SRC_TEST = 4'b1000
  } csr_src_t;

  typedef enum logic [10:0] {
    CSR_H_IDLE = 11'b000_0000_0001,
    CSR_H_LOCK = 11'b000_0000_0010,
    CSR_H_POLL_LOCK = 11'b000_0000_0100,
    CSR_H_POLL_RDY = 11'b000_0000_1000,
    CSR_H_LBA_LO = 11'b000_0001_0000,
    CSR_H_LBA_HI = 11'b000_0010_0000,
    CSR_H_CMD = 11'b000_0100_0000,
    CSR_H_CRESET = 11'b000_1000_0000,
    CSR_H_WAIT_BUF = 11'b001_0000_0000,
    CSR_H_DRAIN = 11'b010_0000_0000,
    CSR_H_RELEASE = 11'b100_0000_0000
  } csr_hstate_t;

endpackage

// file: design/csr_if.sv
`timescale 1ns/100ps
`default_nettype none
interface csr_if;
  logic [6:0] mp_addr;
  logic mp_ce;
  logic mp_we;
  logic mp_oe;
  logic mp_byte_mode;
  logic [15:0] host_d;
  logic host_d_oe;
  logic [15:0] dev_d;
  logic dev_d_oe;
  logic buffer_ready_pin;
  // Shared data bus level worked out from the device enable alone
  logic [15:0] mp_d;
  assign mp_d = dev_d_oe ? dev_d : host_d;

  modport dev (
    input mp_addr, mp_ce, mp_we, mp_oe, mp_byte_mode, mp_d,
    output dev_d, dev_d_oe, buffer_ready_pin
  );
  modport host (
    output mp_addr, mp_ce, mp_we, mp_oe, mp_byte_mode, host_d, host_d_oe,
    input mp_d, buffer_ready_pin
  );
endinterface
`default_nettype wire

// file: design/csr_buf.sv
`timescale 1ns/100ps
`default_nettype none
module csr_buf #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_pop_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic full_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  assign full_o = (cnt_r == (AW+1)'(DEPTH));
  assign in_ready_o = !full_o;
  assign out_valid_o = (cnt_r != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_pop_i && out_valid_o;
  assign out_data_o = mem[rd_ptr_r];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// file: design/csr_host.sv
`timescale 1ns/100ps
`include "csr_defines.svh"
`default_nettype none
module csr_host (
  input wire logic clk_i,
  input wire logic rst_i,
  csr_if.host bus,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [4:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic [15:0] sector_word_o,
  output logic sector_word_valid_o
);
  ////////////////////////////////////////////////////////////////////////////
  csr_pkg::csr_hstate_t st_r;
  logic [27:0] lba_r;
  logic [7:0] count_r;
  logic busy_r;
  logic done_r;
  logic ack_r;
  logic phase_r;
  logic [15:0] left_r;
  logic [4:0] burst_r;
  logic [15:0] word_r;
  logic word_vld_r;
  logic [31:0] dat_r;
  logic [15:0] cfg_r;
  logic cfg_wr_r;
  logic req;
  logic go;

  assign req = cyc_i && stb_i && !ack_r;
  assign go = req && we_i && adr_i == `CSR_WB_CTRL && sel_i[0] && dat_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= '0;
      lba_r <= '0;
      count_r <= '0;
      cfg_r <= '0;
      cfg_wr_r <= 1'b0;
    end else begin
      ack_r <= req;
      cfg_wr_r <= req && we_i && adr_i == `CSR_WB_CFG;
      if (req && we_i && adr_i == `CSR_WB_CFG) begin
        cfg_r <= dat_i[15:0];
      end
      if (req && we_i && adr_i == `CSR_WB_LBA) begin
        lba_r <= dat_i[27:0];
      end
      if (req && we_i && adr_i == `CSR_WB_COUNT && sel_i[0]) begin
        count_r <= dat_i[7:0];
      end
      if (req && !we_i) begin
        case (adr_i)
          `CSR_WB_LBA: dat_r <= {4'h0, lba_r};
          `CSR_WB_COUNT: dat_r <= {24'h00_0000, count_r};
          `CSR_WB_STATUS: dat_r <= {14'h0000, left_r, done_r, busy_r};
          `CSR_WB_LAST: dat_r <= {16'h0000, word_r};
          default: dat_r <= '0;
        endcase
      end
    end
  end
  assign ack_o = ack_r;
  assign dat_o = dat_r;

  ////////////////////////////////////////////////////////////////////////////
  // Port sequencer; reads take two cycles, data sampled in the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= csr_pkg::CSR_H_IDLE;
      phase_r <= 1'b0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      left_r <= '0;
      burst_r <= '0;
      word_r <= '0;
      word_vld_r <= 1'b0;
    end else begin
      word_vld_r <= 1'b0;
      phase_r <= 1'b0;
      case (st_r)
        csr_pkg::CSR_H_IDLE: begin
          if (go && !busy_r) begin
            busy_r <= 1'b1;
            done_r <= 1'b0;
            left_r <= {count_r, 8'h00};
            st_r <= csr_pkg::CSR_H_LOCK;
          end
        end
        csr_pkg::CSR_H_LOCK: st_r <= csr_pkg::CSR_H_POLL_LOCK;
        csr_pkg::CSR_H_POLL_LOCK: begin
          phase_r <= !phase_r;
          if (phase_r && bus.mp_d[`CSR_ST_HOST_LOCK]) begin
            st_r <= csr_pkg::CSR_H_POLL_RDY;
          end
        end
        csr_pkg::CSR_H_POLL_RDY: begin
          phase_r <= !phase_r;
          if (phase_r && bus.mp_d[`CSR_ST_CMD_RDY]) begin
            st_r <= csr_pkg::CSR_H_LBA_LO;
          end
        end
        csr_pkg::CSR_H_LBA_LO: st_r <= csr_pkg::CSR_H_LBA_HI;
        csr_pkg::CSR_H_LBA_HI: st_r <= csr_pkg::CSR_H_CMD;
        csr_pkg::CSR_H_CMD: st_r <= csr_pkg::CSR_H_CRESET;
        csr_pkg::CSR_H_CRESET: begin
          burst_r <= '0;
          st_r <= (left_r == '0) ? csr_pkg::CSR_H_RELEASE : csr_pkg::CSR_H_WAIT_BUF;
        end
        csr_pkg::CSR_H_WAIT_BUF: begin
          if (bus.buffer_ready_pin) begin
            st_r <= csr_pkg::CSR_H_DRAIN;
          end
        end
        csr_pkg::CSR_H_DRAIN: begin
          phase_r <= !phase_r;
          if (phase_r) begin
            word_r <= bus.mp_d;
            word_vld_r <= 1'b1;
            left_r <= left_r - 16'h0001;
            burst_r <= burst_r + 5'h01;
            // Every requested word is read, else the card stalls
            if (left_r == 16'h0001) begin
              st_r <= csr_pkg::CSR_H_RELEASE;
            end else if (burst_r == `CSR_BURST_WORDS - 5'h01) begin
              burst_r <= '0;
              st_r <= csr_pkg::CSR_H_WAIT_BUF;
            end
          end
        end
        csr_pkg::CSR_H_RELEASE: begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
          st_r <= csr_pkg::CSR_H_IDLE;
        end
        default: st_r <= csr_pkg::CSR_H_IDLE;
      endcase
    end
  end
  assign sector_word_o = word_r;
  assign sector_word_valid_o = word_vld_r;

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive, word mode only
  always_comb begin
    bus.mp_addr = '0;
    bus.mp_ce = 1'b0;
    bus.mp_we = 1'b0;
    bus.mp_oe = 1'b0;
    bus.host_d = '0;
    case (st_r)
      // Settings go out only while idle; a sector read overwrites them
      csr_pkg::CSR_H_IDLE: begin
        bus.mp_addr = `CSR_ADR_CTRL;
        bus.mp_we = cfg_wr_r;
        bus.host_d = cfg_r;
      end
      csr_pkg::CSR_H_LOCK: begin
        bus.mp_addr = `CSR_ADR_CTRL;
        bus.mp_we = 1'b1;
        bus.host_d = 16'h0001 << `CSR_CTL_CARD_LOCK_REQUEST;
      end
      csr_pkg::CSR_H_POLL_LOCK, csr_pkg::CSR_H_POLL_RDY: begin
        bus.mp_addr = `CSR_ADR_STATUS;
        bus.mp_oe = !phase_r;
      end
      csr_pkg::CSR_H_LBA_LO: begin
        bus.mp_addr = `CSR_ADR_LBA_LO;
        bus.mp_we = 1'b1;
        bus.host_d = lba_r[15:0];
      end
      csr_pkg::CSR_H_LBA_HI: begin
        bus.mp_addr = `CSR_ADR_LBA_HI;
        bus.mp_we = 1'b1;
        bus.host_d = {4'h0, lba_r[27:16]};
      end
      csr_pkg::CSR_H_CMD: begin
        bus.mp_addr = `CSR_ADR_CNTCMD;
        bus.mp_we = 1'b1;
        bus.host_d = {`CSR_CMD_READ, count_r};
      end
      csr_pkg::CSR_H_CRESET: begin
        bus.mp_addr = `CSR_ADR_CTRL;
        bus.mp_we = 1'b1;
        bus.host_d = (16'h0001 << `CSR_CTL_CARD_LOCK_REQUEST) | (16'h0001 << `CSR_CTL_CRESET);
      end
      csr_pkg::CSR_H_DRAIN: begin
        bus.mp_addr = `CSR_ADR_BUF | {1'b0, burst_r, 1'b0};
        bus.mp_oe = !phase_r;
      end
      csr_pkg::CSR_H_RELEASE: begin
        bus.mp_addr = `CSR_ADR_CTRL;
        bus.mp_we = 1'b1;
      end
      default: bus.mp_addr = '0;
    endcase
    bus.mp_ce = bus.mp_we || bus.mp_oe;
  end
  assign bus.host_d_oe = bus.mp_we;
  assign bus.mp_byte_mode = 1'b0;
endmodule
`default_nettype wire

// file: dv/csr_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module csr_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [6:0] mp_addr,
  input wire logic mp_ce,
  input wire logic mp_we,
  input wire logic mp_oe,
  input wire logic mp_byte_mode,
  input wire logic [15:0] dev_d,
  input wire logic dev_d_oe,
  input wire logic buffer_ready_pin
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic rd;
  logic buf_rd;
  logic st_rd_r;
  logic lock_seen_r;
  assign rd = mp_ce && mp_oe && !mp_we;
  assign buf_rd = rd && mp_addr[6];
  always_ff @(posedge clk_i) begin
    st_rd_r <= !rst_i && rd && (mp_addr == 7'h04);
  end
  // Remembers the grant the host last saw
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_seen_r <= 1'b0;
    end else if (st_rd_r) begin
      lock_seen_r <= dev_d[1];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  chk_read_answer: assert property (rd |=> dev_d_oe)
    else $error("read not answered one cycle later");
  chk_oe_cause: assert property (!rd |=> !dev_d_oe)
    else $error("read data driven without a read");
  chk_data_holds: assert property (!rd |=> $stable(dev_d))
    else $error("read data changed without a read");
  chk_status_pin: assert property (rd && mp_addr == 7'h04 |=> dev_d[5] == $past(buffer_ready_pin))
    else $error("status ready bit differs from ready pin");
  chk_lock_excl: assert property (rd && mp_addr == 7'h04 |=> !(dev_d[0] && dev_d[1]))
    else $error("lock granted to both parties");
  chk_pop_word: assert property (buf_rd && buffer_ready_pin && !mp_byte_mode |=> !buffer_ready_pin)
    else $error("word read did not advance the buffer");
  chk_full_holds: assert property (buffer_ready_pin && !buf_rd |=> buffer_ready_pin)
    else $error("ready dropped without a buffer read");
  chk_drain_locked: assert property (buf_rd |-> lock_seen_r)
    else $error("buffer drained before lock was granted");
  ////////////////////////////////////////////////////////////////////////////
  cover property (buf_rd && buffer_ready_pin);
  cover property (st_rd_r && dev_d[1]);
  cover property (st_rd_r && dev_d[0]);
endmodule
`default_nettype wire

// file: dv/config_source_and_card_sector_read_tb.sv
`timescale 1ns/100ps
`default_nettype none
module config_source_and_card_sector_read_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack;
  logic mode_pin = 1'b1;
  logic [2:0] slot_pins = 3'h5;
  logic chain_req = 1'b0;
  logic cmd_rdy = 1'b1;
  logic [15:0] card_d = 16'h0000;
  logic card_v = 1'b0;
  logic card_rdy;
  logic chain_held, chain_rst, go, start, word_v;
  csr_pkg::csr_src_t src;
  logic [2:0] slot;
  logic [27:0] block_address;
  logic [7:0] cnt;
  logic [15:0] word;
  int failures = 0;
  int cmp_count = 0;
  int starts = 0;
  int words = 0;
  logic [15:0] exp_w = 16'h0000;
  logic saw_creset = 1'b0;
  logic [31:0] q;
  always #25 clk_i = ~clk_i;
  csr_if u_csr_if ();
  csr_dev u_csr_dev (.clk_i(clk_i), .rst_i(rst_i), .bus(u_csr_if.dev),
    .mode_select_pin_i(mode_pin), .design_slot_select_i(slot_pins),
    .chain_lock_req_i(chain_req), .chain_lock_held_o(chain_held),
    .chain_ctrl_reset_o(chain_rst), .config_source_o(src), .design_slot_o(slot),
    .config_go_o(go), .card_cmd_ready_i(cmd_rdy), .card_read_start_o(start),
    .card_lba_o(block_address), .card_count_o(cnt), .card_data_i(card_d),
    .card_data_valid_i(card_v), .card_data_ready_o(card_rdy));
  csr_host u_csr_host (.clk_i(clk_i), .rst_i(rst_i), .bus(u_csr_if.host), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(rdat),
    .ack_o(ack), .sector_word_o(word), .sector_word_valid_o(word_v));
  csr_asserts u_csr_asserts (.clk_i(clk_i), .rst_i(rst_i), .mp_addr(u_csr_if.mp_addr),
    .mp_ce(u_csr_if.mp_ce), .mp_we(u_csr_if.mp_we), .mp_oe(u_csr_if.mp_oe),
    .mp_byte_mode(u_csr_if.mp_byte_mode), .dev_d(u_csr_if.dev_d),
    .dev_d_oe(u_csr_if.dev_d_oe), .buffer_ready_pin(u_csr_if.buffer_ready_pin));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic results();
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Card side streams a counting pattern whenever the device accepts
  always @(posedge clk_i) begin
    if (rst_i) begin
      card_v <= 1'b0;
    end else begin
      card_v <= 1'b1;
      if (card_v && card_rdy) begin
        card_d <= card_d + 16'h0001;
      end
    end
  end
  always @(posedge clk_i) begin
    if (start === 1'b1) begin
      starts++;
    end
    if (word_v === 1'b1) begin
      check({16'h0000, word}, {16'h0000, exp_w});
      exp_w <= exp_w + 16'h0001;
      words++;
      if (chain_rst === 1'b1) begin
        saw_creset <= 1'b1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_defaults();
    repeat (3) @(posedge clk_i);
    check({28'h0, src}, {28'h0, csr_pkg::CSR_SRC_CARD});
    check({31'h0, chain_rst}, 32'h0000_0000);
    check({29'h0, slot}, 32'h0000_0005);
    mode_pin <= 1'b0;
    repeat (3) @(posedge clk_i);
    check({31'h0, src == csr_pkg::CSR_SRC_CARD}, 32'h0000_0000);
    mode_pin <= 1'b1;
    repeat (3) @(posedge clk_i);
    check({28'h0, src}, {28'h0, csr_pkg::CSR_SRC_CARD});
  endtask
  task automatic t_cfg(input logic [15:0] v, input csr_pkg::csr_src_t s);
    wb(1'b1, 5'h14, {16'h0000, v});
    repeat (3) @(posedge clk_i);
    check({28'h0, src}, {28'h0, s});
  endtask
  task automatic t_read(input logic [31:0] a, input logic [7:0] n, input logic hold);
    int s0;
    int w0;
    s0 = starts;
    w0 = words;
    saw_creset = 1'b0;
    wb(1'b1, 5'h04, a);
    wb(1'b1, 5'h08, {24'h0, n});
    wb(1'b1, 5'h00, 32'h0000_0001);
    if (hold) begin
      repeat (40) @(posedge clk_i);
      check({31'h0, chain_held}, 32'h0000_0001);
      check(starts, s0);
      chain_req <= 1'b0;
      repeat (40) @(posedge clk_i);
      check(starts, s0);
      cmd_rdy <= 1'b1;
    end
    do wb(1'b0, 5'h0C, 32'h0); while (q[1] !== 1'b1);
    check(starts, s0 + 1);
    check({4'h0, block_address}, {4'h0, a[27:0]});
    check({24'h0, cnt}, {24'h0, n});
    check(words, w0 + 256 * n);
    check({31'h0, saw_creset}, 32'h0000_0001);
    check({31'h0, chain_rst}, 32'h0000_0000);
    wb(1'b0, 5'h10, 32'h0);
    check(q, {16'h0000, exp_w - 16'h0001});
    wb(1'b0, 5'h14, 32'h0);
    check(q, 32'h0000_0000);
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    check({31'h0, chain_rst}, 32'h0000_0001);
    t_defaults();
    t_cfg(16'h0E00, csr_pkg::CSR_SRC_CARD);
    check({29'h0, slot}, 32'h0000_0006);
    t_cfg(16'h0008, csr_pkg::CSR_SRC_IDLE);
    check({29'h0, slot}, 32'h0000_0005);
    t_cfg(16'h0078, csr_pkg::CSR_SRC_HOST);
    check({31'h0, go}, 32'h0000_0001);
    t_cfg(16'h0058, csr_pkg::CSR_SRC_TEST);
    check({31'h0, go}, 32'h0000_0000);
    t_cfg(16'h0028, csr_pkg::CSR_SRC_CARD);
    t_cfg(16'h0040, csr_pkg::CSR_SRC_TEST);
    chain_req <= 1'b1;
    t_cfg(16'h0000, csr_pkg::CSR_SRC_CARD);
    check({31'h0, chain_held}, 32'h0000_0001);
    t_cfg(16'h0081, csr_pkg::CSR_SRC_IDLE);
    check({31'h0, chain_held}, 32'h0000_0000);
    check({31'h0, chain_rst}, 32'h0000_0001);
    chain_req <= 1'b0;
    t_cfg(16'h0000, csr_pkg::CSR_SRC_CARD);
    t_read(32'hFABC_DEF1, 8'h01, 1'b0);
    chain_req <= 1'b1;
    cmd_rdy <= 1'b0;
    t_read(32'h0000_0010, 8'h02, 1'b1);
    results();
  end
  initial begin
    repeat (30000) @(posedge clk_i);
    failures++;
    results();
  end
endmodule
`default_nettype wire
